/* File: test/pixel_receiver.sv */
// Receiver model that captures the pixel port.
`timescale 1ns/1ps
`default_nettype none
module pixel_receiver (
  input wire logic        clk,
  input wire logic        pclk,
  input wire logic        rowv,
  input wire logic        byte_mode,
  input wire logic [11:0] data,
  input wire logic        sb
);
  logic [11:0] beats[$];
  logic        sats[$];
  int          rv_cycles = 0;
  logic        pclk_d = 1'b0;
  // Sample one core cycle after the pixel clock rises, away from the edge where data moves.
  always @(posedge clk) begin
    pclk_d <= pclk;
    if (rowv) rv_cycles++;
    if (pclk && !pclk_d && rowv) begin
      beats.push_back(byte_mode ? {4'h0, data[7:0]} : data);
      sats.push_back(sb);
    end
  end
endmodule
`default_nettype wire

/* File: test/tof_pixel_output_formatter_assertions.sv */
// Port assertions of the pixel output formatter.
`timescale 1ns/1ps
`default_nettype none
module tof_pixel_output_formatter_assertions (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        SAMPLE_TAKE,
  input wire logic        PIXEL_CLOCK_OUT,
  input wire logic [11:0] PORT_DATA,
  input wire logic        ROW_PAIR_VALID,
  input wire logic        FRAME_VALID,
  input wire logic        AXI_AWVALID,
  input wire logic        AXI_AWREADY,
  input wire logic        AXI_WVALID,
  input wire logic        AXI_WREADY,
  input wire logic        AXI_BVALID,
  input wire logic        AXI_ARVALID,
  input wire logic        AXI_ARREADY,
  input wire logic        AXI_RVALID
);
  // ----
  // Checks
  // ----
  // The edge check assumes the reset polarity, since config is not visible here.
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  a_row_in_frame: assert property (ROW_PAIR_VALID |-> FRAME_VALID)
    else $error("row valid outside frame");
  a_frame_opens_row: assert property ($rose(FRAME_VALID) |-> $rose(ROW_PAIR_VALID))
    else $error("frame opened without row");
  a_change_on_edge: assert property ($changed({PORT_DATA, ROW_PAIR_VALID, FRAME_VALID})
    |-> $rose(PIXEL_CLOCK_OUT)) else $error("output moved off active edge");
  a_idle_data_zero: assert property (!ROW_PAIR_VALID |-> PORT_DATA == 12'h000)
    else $error("data outside row");
  a_take_single: assert property (SAMPLE_TAKE |=> !SAMPLE_TAKE)
    else $error("take longer than one cycle");
  a_take_in_row: assert property (SAMPLE_TAKE |-> ROW_PAIR_VALID)
    else $error("take outside row");
  a_pclk_runs: assert property (PIXEL_CLOCK_OUT |-> ##[1:4] !PIXEL_CLOCK_OUT)
    else $error("pixel clock stuck high");
  a_write_answer: assert property (AXI_AWVALID && AXI_AWREADY && AXI_WVALID && AXI_WREADY
    |-> ##[1:2] AXI_BVALID) else $error("no write response");
  a_read_answer: assert property (AXI_ARVALID && AXI_ARREADY |-> ##[1:2] AXI_RVALID)
    else $error("no read response");
  c_frame: cover property ($rose(FRAME_VALID));
  c_row_end: cover property ($fell(ROW_PAIR_VALID));
  c_write: cover property (AXI_BVALID);
endmodule
bind tof_pixel_output_formatter tof_pixel_output_formatter_assertions port_chk (.CORE_CLK,
  .RESET, .SAMPLE_TAKE, .PIXEL_CLOCK_OUT, .PORT_DATA, .ROW_PAIR_VALID, .FRAME_VALID,
  .AXI_AWVALID, .AXI_AWREADY, .AXI_WVALID, .AXI_WREADY, .AXI_BVALID, .AXI_ARVALID,
  .AXI_ARREADY, .AXI_RVALID);
`default_nettype wire

/* File: test/tof_pixel_output_formatter_tb.sv */
// Self-checking bench of the pixel output formatter.
`timescale 1ns/1ps
`default_nettype none
module tof_pixel_output_formatter_tb;
  logic        clk, rst, trig, ssat, take, pclk, rowv, frmv, sb;
  logic        awv, awrdy, wv, wrdy, bv, bry, arv, arrdy, rvl, rry;
  logic [11:0] sin, pdata, awa, ara;
  logic [31:0] wd, rdat, val;
  logic [1:0]  bre, rre, resp, cur;
  int          idx = 0, cyc = 0, checked = 0, miscompares = 0;
  // Rows: low config bits beside the row-valid length they give.
  logic [3:0]  cfg_t[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb};
  int          len_t[11] = '{1280, 2560, 2560, 1280, 1280, 2560, 2560, 1280, 1280, 2560, 1280};
  // Sample source: pixel n always carries the same value and flag.
  assign sin  = 12'(idx * 341 + 163);
  assign ssat = idx[1];
  tof_pixel_output_formatter dut (
    .CORE_CLK(clk), .RESET(rst), .TRIGGER(trig), .SAMPLE_IN(sin), .SAMPLE_SAT_IN(ssat),
    .SAMPLE_TAKE(take), .PIXEL_CLOCK_OUT(pclk), .PORT_DATA(pdata), .ROW_PAIR_VALID(rowv),
    .FRAME_VALID(frmv), .SATURATION_SIDEBAND(sb), .AXI_AWADDR(awa), .AXI_AWVALID(awv),
    .AXI_AWREADY(awrdy), .AXI_WDATA(wd), .AXI_WSTRB(4'hf), .AXI_WVALID(wv), .AXI_WREADY(wrdy),
    .AXI_BRESP(bre), .AXI_BVALID(bv), .AXI_BREADY(bry), .AXI_ARADDR(ara), .AXI_ARVALID(arv),
    .AXI_ARREADY(arrdy), .AXI_RDATA(rdat), .AXI_RRESP(rre), .AXI_RVALID(rvl), .AXI_RREADY(rry));
  pixel_receiver rx (.clk(clk), .pclk(pclk), .rowv(rowv), .byte_mode(cur != 2'h0),
    .data(pdata), .sb(sb));
  // Clock, sample advance and the run-time ceiling.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    idx <= rst ? 0 : idx + int'(take);
    if (cyc == 45000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // Register bus
  // ----
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, dd;
    @(posedge clk);
    {ad, dd} = 2'b00;
    awa <= a;
    wd <= d;
    {awv, wv, bry} <= 3'b111;
    do begin
      @(posedge clk);
      ad |= awrdy;
      dd |= wrdy;
      awv <= !ad;
      wv <= !dd;
    end while (!(ad && dd));
    while (!bv) @(posedge clk);
    r = bre;
    bry <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    {arv, rry} <= 2'b11;
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    while (!rvl) @(posedge clk);
    d = rdat;
    r = rre;
    rry <= 1'b0;
  endtask
  // Expected port beat n for config bits {force, insert, format}.
  function automatic logic [11:0] beat(input logic [3:0] c, input int n);
    logic [11:0] s;
    logic [7:0]  h, l;
    int          p;
    p = (c[1:0] == 2'h1 || c[1:0] == 2'h2) ? n / 2 : n;
    s = 12'(p * 341 + 163);
    h = {p[1] & c[2], 3'h0, s[11:8]};
    l = s[7:0];
    if (p[1] && c[3]) {s, h, l} = 28'hfffffff;
    case (c[1:0])
      2'h0: return s;
      2'h1: return {4'h0, n[0] ? l : h};
      2'h2: return {4'h0, n[0] ? h : l};
      default: return {4'h0, s[11:4]};
    endcase
  endfunction
  // One measurement up to the end of the first row pair; a new reset ends it.
  task automatic run(input logic [3:0] c, input int len, input bit mid);
    int lat, p;
    lat = 0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axi_wr(tof_fmt_pkg::REG_CONFIG, {24'h0, 4'h8, c}, resp);
    chk("config write", resp, tof_fmt_pkg::RESP_OKAY);
    cur = c[1:0];
    rx.beats.delete();
    rx.sats.delete();
    rx.rv_cycles = 0;
    if (mid) axi_wr(tof_fmt_pkg::REG_CONTROL, 32'h1, resp);
    else trig <= 1'b1;
    while (!rowv && lat < 3000) begin
      @(posedge clk);
      lat++;
      if (lat == 3) trig <= 1'b0;
    end
    chk("start lag", 32'(lat >= 838 && lat <= 848), 32'h1);
    if (mid) axi_wr(tof_fmt_pkg::REG_CONFIG, 32'h83, resp);
    while (rowv && lat < 9000) begin
      @(posedge clk);
      lat++;
    end
    chk("row length", rx.rv_cycles, len);
    chk("beat count", rx.beats.size(), len / 2);
    for (int k = 0; k < 8; k++) begin
      p = (c[1:0] == 2'h1 || c[1:0] == 2'h2) ? k / 2 : k;
      chk("beat", rx.beats[k], beat(c, k));
      chk("sideband", rx.sats[k], p[1]);
    end
    $display("test config %h done", c);
  endtask
  // Main sequence: register access, the format table, then a mid-row change.
  initial begin
    {rst, trig, awv, wv, bry, arv, rry} = 7'h40;
    {awa, ara, wd, cur} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axi_rd(tof_fmt_pkg::REG_CONFIG, val, resp);
    chk("config reset", val, {19'h0, tof_fmt_pkg::CFG_RST});
    axi_wr(12'h0fc, 32'h3, resp);
    chk("unmapped write", resp, tof_fmt_pkg::RESP_SLVERR);
    axi_rd(12'h0fc, val, resp);
    chk("unmapped read", {resp, val}, {tof_fmt_pkg::RESP_SLVERR, 32'h0});
    $display("test register access done");
    for (int r = 0; r < 11; r++) run(cfg_t[r], len_t[r], 1'b0);
    run(4'h0, 1280, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire

/* File: verilog/fmt_if.sv */
// Carrier between the frame sequencer and the pixel formatter.
`timescale 1ns/1ps
`default_nettype none
interface fmt_if;
  logic                start;
  logic                tick;
  logic                eof;
  tof_fmt_pkg::cfg_s   cfg;
  logic [11:0]         sample;
  logic                sample_sat;
  logic                busy;
  logic [11:0]         data;
  logic                row_valid;
  logic                sideband;
  logic                take;

  modport seq (output start, tick, eof, cfg, sample, sample_sat,
               input busy, data, row_valid, sideband, take);
  modport fmt (input start, tick, eof, cfg, sample, sample_sat,
               output busy, data, row_valid, sideband, take);
endinterface
`default_nettype wire

/* File: verilog/pixel_formatter.sv */
// Packs one row pair of samples into the selected output format.
`timescale 1ns/1ps
`default_nettype none
module pixel_formatter (
  input  wire logic CORE_CLK,
  input  wire logic RESET,
  fmt_if.fmt        fi
);
  typedef struct packed {
    logic        act;
    logic        half;
    logic [10:0] cnt;
    logic [11:0] hold;
    logic        hold_sat;
    logic [11:0] data;
    logic        rv;
    logic        sb;
    logic        take;
  } f_s;

  f_s r;
  f_s n;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;

  localparam int HI_MSB_I = tof_fmt_pkg::HI_MSB;
  localparam int HI_LSB_I = tof_fmt_pkg::HI_LSB;
  localparam int LO_MSB_I = tof_fmt_pkg::LO_MSB;
  // High byte carries the flag only when insertion is on, else a zero.
  always_comb begin
    hi_byte = {fi.cfg.sat_insert & fi.sample_sat, 3'h0, fi.sample[HI_MSB_I:HI_LSB_I]}; // RL3 RL4 RL9 RL27
    lo_byte = fi.sample[LO_MSB_I:0];
  end

  // Each active edge within a row pair emits a new pixel, the second half of a split pixel, or ends the row.
  always_comb begin
    n = r;
    n.take = 1'b0;
    if (fi.start) begin
      n.act = 1'b1;
    end
    if (fi.tick) begin
      n.sb = fi.cfg.sideband_eof ? fi.eof : 1'b0;
      if (r.act && r.half) begin
        n.half = 1'b0;
        n.cnt  = r.cnt + 11'h1;
        if (fi.cfg.fmt == tof_fmt_pkg::FMT_HI_LO) begin
          n.data = {4'h0, r.hold[LO_MSB_I:0]}; // RL3
        end else begin
          n.data = {4'h0, r.hold_sat & fi.cfg.sat_insert, 3'h0, r.hold[HI_MSB_I:HI_LSB_I]}; // RL4 RL9
        end
        if (fi.cfg.sat_force && r.hold_sat) begin
          n.data = {4'h0, tof_fmt_pkg::ALL_ONES[LO_MSB_I:0]}; // RL11
        end
        n.sb = fi.cfg.sideband_eof ? fi.eof : r.hold_sat;
      end else if (r.act && r.cnt == tof_fmt_pkg::PIX_PER_PAIR) begin
        n.act  = 1'b0;
        n.cnt  = 11'h0;
        n.rv   = 1'b0; // RL24
        n.data = 12'h000;
      end else if (r.act) begin
        n.rv       = 1'b1; // RL24
        n.take     = 1'b1;
        n.hold     = fi.sample;
        n.hold_sat = fi.sample_sat;
        n.sb       = fi.cfg.sideband_eof ? fi.eof : fi.sample_sat; // RL26
        case (fi.cfg.fmt)
          tof_fmt_pkg::FMT_FULL: begin
            n.data = fi.sample; // RL2 RL6 RL10
            n.cnt  = r.cnt + 11'h1;
          end
          tof_fmt_pkg::FMT_HI_LO: begin
            n.data = {4'h0, hi_byte}; // RL3 RL6
            n.half = 1'b1; // RL8
          end
          tof_fmt_pkg::FMT_LO_HI: begin
            n.data = {4'h0, lo_byte}; // RL4 RL6
            n.half = 1'b1; // RL8
          end
          default: begin
            n.data = {4'h0, fi.sample[HI_MSB_I:tof_fmt_pkg::TR_LSB]}; // RL5 RL10
            n.cnt  = r.cnt + 11'h1;
          end
        endcase
        if (fi.cfg.sat_force && fi.sample_sat) begin
          n.data = (fi.cfg.fmt == tof_fmt_pkg::FMT_FULL) ? tof_fmt_pkg::ALL_ONES
                   : {4'h0, tof_fmt_pkg::ALL_ONES[LO_MSB_I:0]}; // RL11
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign fi.busy      = r.act;
  assign fi.data      = r.data;
  assign fi.row_valid = r.rv;
  assign fi.sideband  = r.sb;
  assign fi.take      = r.take;
endmodule
`default_nettype wire

/* File: verilog/tof_fmt_pkg.sv */
// Shared constants, field layouts and types of the pixel output formatter.
package tof_fmt_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CORE_PERIOD_NS = 100;
  localparam int unsigned TRIG_LAG_NS    = 18000;
  localparam int unsigned INTEG_NS       = 1000;
  localparam int unsigned PROC_DELAY_NS  = 38750;
  localparam int unsigned CONV_NS        = 26042;
  localparam int unsigned NEXT_LAG_NS    = 17000;
  localparam int unsigned FRAME_END_NS   = 50;
  localparam int unsigned TRIG_HOLD_NS   = 250;

  // Typical figures are rounded up to whole cycles and never fall below one.
  localparam logic [11:0] TRIG_LAG_CYC  = 12'((TRIG_LAG_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [11:0] INTEG_CYC     = 12'((INTEG_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [11:0] PROC_CYC      = 12'((PROC_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [11:0] ROW_CONV_CYC  = 12'(2 * ((CONV_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS));
  localparam logic [11:0] NEXT_LAG_CYC  = 12'((NEXT_LAG_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [11:0] FRAME_END_CYC = 12'((FRAME_END_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

  // Half periods of the pixel clock in core cycles, ratios kept at 48:24:12.
  localparam logic [2:0] HALF_FAST = 3'h1;
  localparam logic [2:0] HALF_MID  = 3'h2;
  localparam logic [2:0] HALF_SLOW = 3'h4;

  // ---------------------------------------------------------------------------
  // Geometry and sample layout
  // ---------------------------------------------------------------------------
  localparam logic [6:0]  ROW_PAIRS    = 7'h78;
  localparam logic [10:0] PIX_PER_PAIR = 11'h280;
  localparam int HI_MSB  = 11;
  localparam int HI_LSB  = 8;
  localparam int LO_MSB  = 7;
  localparam int TR_LSB  = 4;
  localparam int BYTE_W  = 8;
  localparam logic [11:0] ALL_ONES = 12'hfff;

  typedef enum logic [1:0] {
    FMT_FULL = 2'h0, FMT_HI_LO = 2'h1, FMT_LO_HI = 2'h2, FMT_TRUNC = 2'h3
  } fmt_e;

  typedef struct packed {
    logic       continuous;
    logic [3:0] frames_m1;
    logic       clk_pol;
    logic [1:0] clk_sel;
    logic       sideband_eof;
    logic       sat_force;
    logic       sat_insert;
    fmt_e       fmt;
  } cfg_s;
  localparam int CFG_W = $bits(cfg_s);
  localparam logic [12:0] CFG_RST = 13'h0080;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] REG_CONFIG  = 12'h000;
  localparam logic [11:0] REG_CONTROL = 12'h004;
  localparam logic [11:0] REG_STATUS  = 12'h008;
  localparam int CTL_TRIG = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: verilog/tof_pixel_output_formatter.sv */
// Frame sequencer, pixel clock and register slave of the pixel output port.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RL1) Four formats: full 12-bit and three byte-wide forms of the sample.
// (RL2) Full-width format shows each sample in one pixel clock cycle.
// (RL3) High-first split: flag, zeros, bits 11..8, then bits 7..0.
// (RL4) Low-first split: bits 7..0, then flag, zeros, bits 11..8.
// (RL5) Truncated format: one cycle carrying bits 11..4 on low lines.
// (RL6) Full width drives twelve lines; byte formats use only eight low lines.
// (RL7) A software field selects the active format.
// (RL8) Split formats keep row valid high twice as long per row pair.
// (RL9) Saturation insert puts the flag on bit 7 of the high byte.
// (RL10) No insertion in full-width or truncated formats.
// (RL11) Saturation force drives all lines high for saturated pixels.
// (RL12) Receiver combines four or two frames into one distance result.
// (RL13) Trigger driver holds the trigger for the minimum pulse time.
// (RL14) Trigger rising edge to first illumination waits the trigger lag.
// (RL15) Processing delay from last illumination to first row conversion.
// (RL16) A half row pair converts in the conversion time.
// (RL17) Row pair readout runs with row valid asserted throughout.
// (RL18) Frame valid drops a short lag after the final row valid.
// (RL19) Frame readout spans all row conversions, one readout and end lag.
// (RL20) Single measurement starts readout a fixed delay after the trigger.
// (RL21) Continuous mode: next illumination follows last readout by a lag.
// (RL22) Continuous frame period sums conversions, lag, integration, processing.
// (RL23) Outputs change only on the programmed active pixel clock edge.
// (RL24) Row valid frames the valid data and sideband of each row pair.
// (RL25) Pixel clock toggles continuously at one of three rates.
// (RL26) By default the sideband carries each pixel's saturation flag.
// (RL27) Split formats without insertion drive bit 7 of the high byte zero.
// (RL28) Format and saturation settings are taken only between frames.
module tof_pixel_output_formatter (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        TRIGGER,
  input  wire logic [11:0] SAMPLE_IN,
  input  wire logic        SAMPLE_SAT_IN,
  output logic             SAMPLE_TAKE,
  output logic             PIXEL_CLOCK_OUT,
  output logic [11:0]      PORT_DATA,
  output logic             ROW_PAIR_VALID,
  output logic             FRAME_VALID,
  output logic             SATURATION_SIDEBAND,
  input  wire logic [11:0] AXI_AWADDR,
  input  wire logic        AXI_AWVALID,
  output logic             AXI_AWREADY,
  input  wire logic [31:0] AXI_WDATA,
  input  wire logic [3:0]  AXI_WSTRB,
  input  wire logic        AXI_WVALID,
  output logic             AXI_WREADY,
  output logic [1:0]       AXI_BRESP,
  output logic             AXI_BVALID,
  input  wire logic        AXI_BREADY,
  input  wire logic [11:0] AXI_ARADDR,
  input  wire logic        AXI_ARVALID,
  output logic             AXI_ARREADY,
  output logic [31:0]      AXI_RDATA,
  output logic [1:0]       AXI_RRESP,
  output logic             AXI_RVALID,
  input  wire logic        AXI_RREADY
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // Gray codes along the usual path idle, lag, integrate, process, convert.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LAG   = 3'h1,
    ST_INTEG = 3'h3,
    ST_PROC  = 3'h2,
    ST_CONV  = 3'h6,
    ST_LAST  = 3'h7,
    ST_FEND  = 3'h5
  } seq_e;

  typedef struct packed {
    seq_e              st;
    logic [11:0]       timer;
    logic [6:0]        row;
    logic [3:0]        frames_left;
    logic [7:0]        frame_cnt;
    tof_fmt_pkg::cfg_s cfg;
    tof_fmt_pkg::cfg_s cfg_act;
    logic              trig_s1;
    logic              trig_s2;
    logic              trig_s3;
    logic              sw_trig;
    logic [2:0]        div;
    logic              pclk;
    logic              fv;
    logic              fv_pend;
    logic              start;
    logic              eof;
    logic              aw_ok;
    logic [11:0]       awaddr;
    logic              w_ok;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } top_s;

  top_s  r;
  top_s  n;
  fmt_if fi ();

  tof_fmt_pkg::cfg_s clk_cfg;
  logic [2:0]        half;
  logic              toggle;
  logic              tick;
  logic              trig_rise;
  logic [31:0]       cfg32;

  // ---------------------------------------------------------------------------
  // Pixel clock divider
  // ---------------------------------------------------------------------------
  // The clock never stops; while a measurement runs its rate and polarity
  // come from the settings frozen at frame start, so a frame never changes
  // speed half way through.
  always_comb begin
    clk_cfg = (r.st == ST_IDLE) ? r.cfg : r.cfg_act;
    case (clk_cfg.clk_sel)
      2'h0:    half = tof_fmt_pkg::HALF_FAST; // RL25
      2'h1:    half = tof_fmt_pkg::HALF_MID; // RL25
      default: half = tof_fmt_pkg::HALF_SLOW; // RL25
    endcase
    toggle    = (r.div >= half - 3'h1);
    tick      = toggle && ((~r.pclk) == clk_cfg.clk_pol); // RL23
    trig_rise = r.trig_s2 && !r.trig_s3;
  end

  // Interface drive toward the formatter.
  assign fi.start      = r.start;
  assign fi.tick       = tick;
  assign fi.eof        = r.eof;
  assign fi.cfg        = r.cfg_act;
  assign fi.sample     = SAMPLE_IN;
  assign fi.sample_sat = SAMPLE_SAT_IN;

  pixel_formatter u_fmt (
    .CORE_CLK (CORE_CLK),
    .RESET    (RESET),
    .fi       (fi)
  );

  // ---------------------------------------------------------------------------
  // Sequencer and register slave
  // ---------------------------------------------------------------------------
  always_comb begin
    n     = r;
    cfg32 = 32'(r.cfg);

    // Trigger pin synchroniser; only the second and third stages are read.
    n.trig_s1 = TRIGGER;
    n.trig_s2 = r.trig_s1;
    n.trig_s3 = r.trig_s2;

    // Divider runs every cycle.
    if (toggle) begin
      n.div  = 3'h0;
      n.pclk = ~r.pclk; // RL25
    end else begin
      n.div = r.div + 3'h1;
    end

    n.start = 1'b0;
    if (tick && r.fv_pend && fi.busy) begin
      n.fv      = 1'b1; // RL23
      n.fv_pend = 1'b0;
    end
    if (r.timer != 12'h000) begin
      n.timer = r.timer - 12'h001;
    end

    case (r.st)
      ST_IDLE: begin
        if (trig_rise || r.sw_trig) begin
          n.sw_trig     = 1'b0;
          n.cfg_act     = r.cfg; // RL7 RL28
          n.frames_left = r.cfg.frames_m1;
          n.timer       = tof_fmt_pkg::TRIG_LAG_CYC; // RL14 RL20
          n.st          = ST_LAG;
        end
      end
      ST_LAG: begin
        if (r.timer <= 12'h001) begin
          n.timer = tof_fmt_pkg::INTEG_CYC;
          n.st    = ST_INTEG;
        end
      end
      ST_INTEG: begin
        if (r.timer <= 12'h001) begin
          n.timer = tof_fmt_pkg::PROC_CYC; // RL15
          n.st    = ST_PROC;
        end
      end
      ST_PROC: begin
        if (r.timer <= 12'h001) begin
          n.timer = tof_fmt_pkg::ROW_CONV_CYC >> 1; // RL16 RL20
          n.row   = 7'h00;
          n.st    = ST_CONV;
        end
      end
      ST_CONV: begin
        // Row pair readout outlasts a conversion at every pixel clock rate; the next row then
        // waits for the port, which stretches the frame instead of losing rows.
        if (r.timer == 12'h000 && !fi.busy && !r.start) begin
          n.start = 1'b1; // RL17
          n.timer = tof_fmt_pkg::ROW_CONV_CYC; // RL16 RL19
          n.row   = r.row + 7'h01;
          if (r.row == 7'h00) begin
            n.fv_pend = 1'b1;
          end
          if (r.row == tof_fmt_pkg::ROW_PAIRS - 7'h01) begin
            n.st = ST_LAST;
          end
        end
      end
      ST_LAST: begin
        if (!fi.busy && !r.start && !fi.row_valid) begin
          n.timer = tof_fmt_pkg::FRAME_END_CYC; // RL18
          n.eof   = 1'b1;
          n.st    = ST_FEND;
        end
      end
      ST_FEND: begin
        if (r.timer == 12'h000 && tick) begin
          n.fv        = 1'b0; // RL18 RL19
          n.eof       = 1'b0;
          n.frame_cnt = r.frame_cnt + 8'h01;
          n.timer     = tof_fmt_pkg::NEXT_LAG_CYC; // RL21 RL22
          if (r.frames_left != 4'h0) begin
            n.frames_left = r.frames_left - 4'h1;
            n.st          = ST_LAG;
          end else if (r.cfg.continuous || r.trig_s2) begin
            n.cfg_act     = r.cfg; // RL28
            n.frames_left = r.cfg.frames_m1;
            n.st          = ST_LAG;
          end else begin
            n.timer = 12'h000;
            n.st    = ST_IDLE;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Write channel: address and data taken independently, in either order.
    if (r.bvalid && AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_ok && r.w_ok && !r.bvalid) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = tof_fmt_pkg::RESP_OKAY;
      if (r.awaddr == tof_fmt_pkg::REG_CONFIG) begin
        for (int b = 0; b < 4; b++) begin
          if (r.wstrb[b]) begin
            cfg32[b*tof_fmt_pkg::BYTE_W +: tof_fmt_pkg::BYTE_W] =
              r.wdata[b*tof_fmt_pkg::BYTE_W +: tof_fmt_pkg::BYTE_W];
          end
        end
        n.cfg = tof_fmt_pkg::cfg_s'(cfg32[tof_fmt_pkg::CFG_W-1:0]); // RL1 RL7
      end else if (r.awaddr == tof_fmt_pkg::REG_CONTROL) begin
        // Set after the idle state's clear, so a request is never lost.
        if (r.wstrb[0] && r.wdata[tof_fmt_pkg::CTL_TRIG]) begin
          n.sw_trig = 1'b1;
        end
      end else if (r.awaddr == tof_fmt_pkg::REG_STATUS) begin
        n.bresp = tof_fmt_pkg::RESP_OKAY;
      end else begin
        n.bresp = tof_fmt_pkg::RESP_SLVERR;
      end
    end
    if (AXI_AWVALID && r.awready) begin
      n.aw_ok  = 1'b1;
      n.awaddr = AXI_AWADDR;
    end
    if (AXI_WVALID && r.wready) begin
      n.w_ok  = 1'b1;
      n.wdata = AXI_WDATA;
      n.wstrb = AXI_WSTRB;
    end

    // Read channel: one cycle from address to data.
    if (r.rvalid && AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (AXI_ARVALID && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = tof_fmt_pkg::RESP_OKAY;
      if (AXI_ARADDR == tof_fmt_pkg::REG_CONFIG) begin
        n.rdata = 32'(r.cfg);
      end else if (AXI_ARADDR == tof_fmt_pkg::REG_CONTROL) begin
        n.rdata = 32'h0000_0000;
      end else if (AXI_ARADDR == tof_fmt_pkg::REG_STATUS) begin
        n.rdata = 32'({r.frame_cnt, r.row, r.fv, fi.busy, r.st});
      end else begin
        n.rdata = 32'h0000_0000;
        n.rresp = tof_fmt_pkg::RESP_SLVERR;
      end
    end

    // Ready flags are registered so every bus output comes from a flop.
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready  = !n.w_ok && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      r     <= '0;
      r.cfg <= tof_fmt_pkg::cfg_s'(tof_fmt_pkg::CFG_RST);
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // All of these are flops here or inside the formatter.
  assign SAMPLE_TAKE         = fi.take;
  assign PIXEL_CLOCK_OUT     = r.pclk;
  assign PORT_DATA           = fi.data; // RL6
  assign ROW_PAIR_VALID      = fi.row_valid; // RL8 RL24
  assign FRAME_VALID         = r.fv;
  assign SATURATION_SIDEBAND = fi.sideband; // RL26
  assign AXI_AWREADY         = r.awready;
  assign AXI_WREADY          = r.wready;
  assign AXI_BRESP           = r.bresp;
  assign AXI_BVALID          = r.bvalid;
  assign AXI_ARREADY         = r.arready;
  assign AXI_RDATA           = r.rdata;
  assign AXI_RRESP           = r.rresp;
  assign AXI_RVALID          = r.rvalid;

endmodule
`default_nettype wire
